//--- pmt_consts.vh
// pmt_consts.vh: offsets, fields, reset values for the period match timer
// assumes: included by the timer design files and the testbench
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH
`define PMT_OFS_CONTROL   12'h000
`define PMT_OFS_COUNT     12'h004
`define PMT_OFS_PERIOD    12'h008
`define PMT_OFS_FLAG      12'h00C
`define PMT_OFS_ENABLE    12'h010
`define PMT_OFS_STATUS    12'h014
`define PMT_CTL_PRE_LSB   0
`define PMT_CTL_ON_BIT    2
`define PMT_CTL_POST_LSB  3
`define PMT_CTL_MASK      8'h7F
`define PMT_COUNT_RESET   8'h00
`define PMT_PERIOD_RESET  8'hFF
`define PMT_CONTROL_RESET 8'h00
`define PMT_PRE_DIV1      2'h0
`define PMT_PRE_DIV4      2'h1
`define PMT_PRE_DIV16     2'h2
`define PMT_PRE_DIV64     2'h3
`define PMT_FOSC_DIV      4
`endif

//--- pmt_far_model.sv
// pmt_far_model.sv: pwm unit and serial port side, counts time base events
// assumes: same clock as the timer
`timescale 1ns/100ps
`default_nettype none
module pmt_far_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       time_base,
  input  wire logic       shift_clk,
  output var  logic [7:0] n_base,
  output var  logic [7:0] n_edge
);
  logic last_clk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_base <= 8'h00;
      n_edge <= 8'h00;
      last_clk <= 1'h0;
    end else begin
      last_clk <= shift_clk;
      if (time_base) n_base <= n_base + 8'h01;
      if (shift_clk != last_clk) n_edge <= n_edge + 8'h01;
    end
  end
endmodule // pmt_far_model
`default_nettype wire

//--- pmt_postscaler.v
// pmt_postscaler.v: counts matches, emits one event per N+1 matches
// assumes: match pulse is one cycle wide, same clock
`timescale 1ns/100ps
`default_nettype none
module pmt_postscaler (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       clear,
  input  wire       match,
  input  wire [3:0] postscale_select,
  output reg        event_out
);
  reg [3:0] match_count;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_count <= 4'h0;
      event_out   <= 1'b0;
    end else if (clear) begin
      match_count <= 4'h0;
      event_out   <= 1'b0;
    end else if (match) begin
      event_out <= (match_count >= postscale_select);
      if (match_count >= postscale_select)
        match_count <= 4'h0;
      else
        match_count <= match_count + 4'h1;
    end else begin
      event_out <= 1'b0;
    end
  end
endmodule // pmt_postscaler
`default_nettype wire

//--- pmt_prescaler.v
// pmt_prescaler.v: tick divider by 1, 4, 16 or 64
// assumes: clear comes from the register logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "pmt_consts.vh"
module pmt_prescaler (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       clear,
  input  wire       tick_in,
  input  wire [1:0] prescale_select,
  output reg        tick_out
);
  reg  [5:0] div_count;
  reg  [5:0] last_val;

  always @* begin
    case (prescale_select)
      `PMT_PRE_DIV1:  last_val = 6'h00;
      `PMT_PRE_DIV4:  last_val = 6'h03;
      `PMT_PRE_DIV16: last_val = 6'h0F;
      default:        last_val = 6'h3F;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count <= 6'h00;
      tick_out  <= 1'b0;
    end else if (clear) begin
      div_count <= 6'h00;
      tick_out  <= 1'b0;
    end else if (tick_in) begin
      tick_out <= (div_count >= last_val);
      if (div_count >= last_val)
        div_count <= 6'h00;
      else
        div_count <= div_count + 6'h01;
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // pmt_prescaler
`default_nettype wire

//--- pmt_timer.v
// pmt_timer.v: 8-bit period match timer with AHB-Lite register slave
// assumes: hclk is the oscillator; one master; whole-word transfers only;
// sleep_req and reset cause levels come from the same clock domain.
//
// How it works
// - count clock is oscillator divided by four
// - prescaler divides by 1, 4, 16, 64
// - match output when count equals period
// - count clears after match; match clocks postscaler
// - software reads and writes count and period
// - reset: count zero, period all ones
// - scalers clear on count/control write, resets
// - control write leaves count unchanged
// - each match advances 4-bit postscaler
// - postscaled event sets sticky match flag
// - flag interrupts only while enable set
// - four-bit field picks sixteen postscale ratios
// - unscaled match drives capture/compare/PWM time base
// - match offered as SPI shift clock
// - no counting during sleep
// - sleep keeps count and period
// - timer_on bit starts and stops counting
// - prescale codes 00,01,10,11 map 1,4,16,64
// - postscale value N gives N+1 matches
// - period is period_value plus one ticks
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pmt_consts.vh"
module pmt_timer (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  input  wire        sleep_req,
  input  wire        soft_reset,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         match_pulse,
  output reg         ccp_time_base,
  output reg         spi_shift_clk,
  output reg         match_irq
);
  // control state
  reg  [7:0]  timer_control;
  reg  [7:0]  timer_count;
  reg  [7:0]  period_value;
  reg         match_int_flag;
  reg         match_int_enable;
  // instruction clock divider
  reg  [1:0]  inst_div;
  reg         inst_tick;
  // bus data phase
  reg         dp_write;
  reg         dp_read;
  reg  [11:0] dp_addr;
  reg  [7:0]  next_count;
  reg  [31:0] next_rdata;
  reg         soft_q;
  wire        pre_tick;
  wire        post_event;
  wire        addr_take;
  wire        wr_count;
  wire        wr_control;
  wire        wr_period;
  wire        wr_flag;
  wire        wr_enable;
  wire        scaler_clear;
  wire        counting;
  wire        match_now;
  wire [1:0]  prescale_select;
  wire [3:0]  postscale_select;
  wire        timer_on;

  function is_reg;
    input [11:0] a;
    input [11:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  assign prescale_select  = timer_control[`PMT_CTL_PRE_LSB +: 2];
  assign postscale_select = timer_control[`PMT_CTL_POST_LSB +: 4];
  assign timer_on         = timer_control[`PMT_CTL_ON_BIT];

  assign addr_take  = hsel & hready & htrans[1];
  assign wr_count   = dp_write & is_reg(dp_addr, `PMT_OFS_COUNT);
  assign wr_control = dp_write & is_reg(dp_addr, `PMT_OFS_CONTROL);
  assign wr_period  = dp_write & is_reg(dp_addr, `PMT_OFS_PERIOD);
  assign wr_flag    = dp_write & is_reg(dp_addr, `PMT_OFS_FLAG);
  assign wr_enable  = dp_write & is_reg(dp_addr, `PMT_OFS_ENABLE);
  // software reset reloads count, period and control and clears enable and scalers; the match flag keeps its value
  assign scaler_clear = wr_count | wr_control | soft_q;

  // halting the count in sleep also freezes count and period
  assign counting  = timer_on & ~sleep_req;
  assign match_now = pre_tick & counting & (timer_count == period_value);

  // instruction clock: one enable per four oscillator cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inst_div  <= 2'h0;
      inst_tick <= 1'b0;
    end else begin
      inst_div  <= inst_div + 2'h1;
      inst_tick <= (inst_div == `PMT_FOSC_DIV - 1);
    end
  end

  pmt_prescaler u_pre (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .clear           (scaler_clear),
    .tick_in         (inst_tick & counting),
    .prescale_select (prescale_select),
    .tick_out        (pre_tick)
  );

  pmt_postscaler u_post (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .clear            (scaler_clear),
    .match            (match_now),
    .postscale_select (postscale_select),
    .event_out        (post_event)
  );

  always @* begin
    next_count = timer_count;
    if (pre_tick & counting) begin
      if (timer_count == period_value)
        next_count = `PMT_COUNT_RESET;
      else
        next_count = timer_count + 8'h01;
    end
    if (wr_count)
      next_count = hwdata[7:0];
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_reset;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count   <= `PMT_COUNT_RESET;
      period_value  <= `PMT_PERIOD_RESET;
      timer_control <= `PMT_CONTROL_RESET;
    end else if (soft_q) begin
      timer_count   <= `PMT_COUNT_RESET;
      period_value  <= `PMT_PERIOD_RESET;
      timer_control <= `PMT_CONTROL_RESET;
    end else begin
      timer_count <= next_count;
      if (wr_period)
        period_value <= hwdata[7:0];
      if (wr_control)
        timer_control <= hwdata[7:0] & `PMT_CTL_MASK;
    end
  end

  // flag: hardware set wins over a software clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_int_flag   <= 1'b0;
      match_int_enable <= 1'b0;
    end else begin
      if (post_event)
        match_int_flag <= 1'b1;
      else if (wr_flag)
        match_int_flag <= hwdata[0];
      if (soft_q)
        match_int_enable <= 1'b0;
      else if (wr_enable)
        match_int_enable <= hwdata[0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_pulse   <= 1'b0;
      ccp_time_base <= 1'b0;
      spi_shift_clk <= 1'b0;
      match_irq     <= 1'b0;
    end else begin
      match_pulse   <= match_now;
      ccp_time_base <= match_now;
      // spi port divides this further; a toggle gives a 50% clock
      if (match_now)
        spi_shift_clk <= ~spi_shift_clk;
      match_irq <= (match_int_flag | post_event) & match_int_enable;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr)
      `PMT_OFS_CONTROL: next_rdata[7:0] = timer_control;
      `PMT_OFS_COUNT:   next_rdata[7:0] = next_count;
      `PMT_OFS_PERIOD:  next_rdata[7:0] = period_value;
      `PMT_OFS_FLAG:    next_rdata[0]   = match_int_flag;
      `PMT_OFS_ENABLE:  next_rdata[0]   = match_int_enable;
      `PMT_OFS_STATUS:  next_rdata[1:0] = {sleep_req, counting};
      default:          next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_read   <= 1'b0;
      dp_addr   <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_write  <= addr_take & hwrite;
      dp_read   <= addr_take & ~hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_take)
        dp_addr <= haddr;
      if (addr_take & ~hwrite)
        hrdata <= next_rdata;
    end
  end
endmodule // pmt_timer
`default_nettype wire

//--- pmt_timer_assertions.sv
// pmt_timer_assertions.sv: port checker for the period match timer
// assumes: bound to pmt_timer, one clock domain
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        sleep_req,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        match_pulse,
  input wire logic        ccp_time_base,
  input wire logic        spi_shift_clk
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout)
    else $error("hreadyout low");
  AST_OKAY: assert property (!hresp)
    else $error("hresp not okay");
  AST_UPPER: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_BASE: assert property (ccp_time_base == match_pulse)
    else $error("time base differs from match");
  AST_SPI: assert property (match_pulse |-> $changed(spi_shift_clk))
    else $error("shift clock missed a match");
  AST_GAP: assert property (match_pulse |=> !match_pulse [*3])
    else $error("matches closer than one instruction tick");
  AST_SLEEP: assert property (sleep_req [*4] |-> !match_pulse)
    else $error("match while asleep");
  AST_SLEEP_HOLD: assert property (sleep_req [*4] |->
    $stable(spi_shift_clk))
    else $error("shift clock moved while asleep");
endmodule // pmt_timer_chk
bind pmt_timer pmt_timer_chk u_chk (.hclk, .hresetn, .sleep_req, .hrdata,
  .hreadyout, .hresp, .match_pulse, .ccp_time_base, .spi_shift_clk);
`default_nettype wire

//--- pmt_timer_tb.sv
// pmt_timer_tb.sv: self-checking bench for the period match timer
// assumes: single AHB slave, hready looped from hreadyout
`timescale 1ns/100ps
`default_nettype none
`include "pmt_consts.vh"
module pmt_timer_tb;
  logic hclk, hresetn, hwrite, sleep_req, soft_reset;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire  [7:0]  n_base, n_edge;
  wire hreadyout, hresp, match_pulse, ccp_time_base, spi_shift_clk, match_irq;
  int n_mismatch = 0;
  int total_checks = 0;
  pmt_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .sleep_req(sleep_req),
    .soft_reset(soft_reset), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .match_pulse(match_pulse),
    .ccp_time_base(ccp_time_base), .spi_shift_clk(spi_shift_clk),
    .match_irq(match_irq));
  pmt_far_model far (.hclk(hclk), .hresetn(hresetn),
    .time_base(ccp_time_base), .shift_clk(spi_shift_clk),
    .n_base(n_base), .n_edge(n_edge));
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  // idle edge after a write so a following read sees the new value
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'h1, d, r);
    @(posedge hclk);
  endtask
  task automatic rc(input string s, input logic [11:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'h0, 32'h0, r);
    chk(s, r, e);
  endtask
  task automatic gap(output int n);
    do @(posedge hclk); while (match_pulse !== 1'h1);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (match_pulse !== 1'h1);
  endtask
  task automatic t_regs;
    rc("count", `PMT_OFS_COUNT, 32'h00);
    rc("period", `PMT_OFS_PERIOD, 32'hFF);
    wr(`PMT_OFS_PERIOD, 32'h5A);
    rc("period", `PMT_OFS_PERIOD, 32'h5A);
    wr(`PMT_OFS_COUNT, 32'hA5);
    rc("count", `PMT_OFS_COUNT, 32'hA5);
    rc("unmapped", 12'h020, 32'h00);
    wr(`PMT_OFS_CONTROL, 32'hFB);
    rc("control", `PMT_OFS_CONTROL, 32'h7B);
    rc("count", `PMT_OFS_COUNT, 32'hA5);
    soft_reset <= 1'h1;
    @(posedge hclk);
    soft_reset <= 1'h0;
    repeat (2) @(posedge hclk);
    rc("count", `PMT_OFS_COUNT, 32'h00);
    rc("period", `PMT_OFS_PERIOD, 32'hFF);
    rc("control", `PMT_OFS_CONTROL, 32'h00);
  endtask
  task automatic t_run;
    logic [31:0] r;
    wr(`PMT_OFS_COUNT, 32'h10);
    wr(`PMT_OFS_CONTROL, 32'h04);
    repeat (38) @(posedge hclk);
    wr(`PMT_OFS_CONTROL, 32'h00);
    bus(`PMT_OFS_COUNT, 1'h0, 32'h0, r);
    chk("count steps", 32'(r >= 32'h19 && r <= 32'h1B), 32'h1);
    repeat (20) @(posedge hclk);
    rc("count off", `PMT_OFS_COUNT, r);
  endtask
  task automatic t_presc;
    int n, k;
    logic [7:0] b, e;
    wr(`PMT_OFS_PERIOD, 32'h03);
    for (k = 0; k < 4; k++) begin
      wr(`PMT_OFS_CONTROL, 32'h04 | k);
      gap(n);
      repeat (2) @(posedge hclk);
      b = n_base;
      e = n_edge;
      gap(n);
      chk("match gap", n, 32'd16 << (2 * k));
      repeat (2) @(posedge hclk);
      // second gap spans two matches: the one it waits for, the closing one
      chk("time base", n_base - b, 32'h2);
      chk("shift clk", n_edge - e, 32'h2);
    end
  endtask
  task automatic t_post;
    int n, k;
    wr(`PMT_OFS_ENABLE, 32'h01);
    for (k = 0; k < 16; k++) begin
      wr(`PMT_OFS_CONTROL, 32'h00);
      wr(`PMT_OFS_FLAG, 32'h00);
      wr(`PMT_OFS_COUNT, 32'h00);
      wr(`PMT_OFS_CONTROL, 32'h04 | (k << 3));
      n = 0;
      while (match_irq !== 1'h1 && n < 40) begin
        @(posedge hclk);
        if (match_pulse === 1'h1) n++;
      end
      chk("matches per event", n, k + 1);
    end
    wr(`PMT_OFS_ENABLE, 32'h00);
    rc("enable", `PMT_OFS_ENABLE, 32'h00);
    repeat (2) @(posedge hclk);
    chk("irq masked", match_irq, 32'h0);
    rc("flag", `PMT_OFS_FLAG, 32'h01);
  endtask
  task automatic t_sleep;
    logic [31:0] r1, r2;
    sleep_req <= 1'h1;
    repeat (4) @(posedge hclk);
    bus(`PMT_OFS_COUNT, 1'h0, 32'h0, r1);
    repeat (40) @(posedge hclk);
    bus(`PMT_OFS_COUNT, 1'h0, 32'h0, r2);
    chk("count asleep", r2, r1);
    rc("period asleep", `PMT_OFS_PERIOD, 32'h03);
    rc("status asleep", `PMT_OFS_STATUS, 32'h2);
    sleep_req <= 1'h0;
    rc("status awake", `PMT_OFS_STATUS, 32'h1);
  endtask
  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    #3000000;
    n_mismatch++;
    test_done;
  end
  initial begin
    hresetn = 1'h0;
    htrans = 2'h0;
    haddr = 12'h000;
    hwrite = 1'h0;
    hwdata = 32'h0;
    sleep_req = 1'h0;
    soft_reset = 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs;
    t_run;
    t_presc;
    t_post;
    t_sleep;
    test_done;
  end
endmodule // pmt_timer_tb
`default_nettype wire
